//--- iop_map.svh
// Register indices, field positions and reset values of the I/O port
`ifndef IOP_MAP_SVH
`define IOP_MAP_SVH

`define IOP_IDX_W 4
`define IOP_REG_COUNT 10
`define IOP_IDX_DIR 4'h0
`define IOP_IDX_PORT 4'h1
`define IOP_IDX_LAT 4'h2
`define IOP_IDX_ODC 4'h3
`define IOP_IDX_ANSEL 4'h4
`define IOP_IDX_CNEN 4'h5
`define IOP_IDX_CNSTAT 4'h6
`define IOP_IDX_CNPU 4'h7
`define IOP_IDX_CNPD 4'h8
`define IOP_IDX_CNCON 4'h9

`define IOP_DIR_RST 16'hffff
`define IOP_ANSEL_RST 16'hffff
`define IOP_ZERO_RST 16'h0000
`define IOP_CNCON_ON_BIT 15

`endif

//--- iop_pad.sv
// Output driver, enable and pull controls of one port pin
`timescale 1ns/1ps
module iop_pad (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic dir_in,
  input wire logic latch,
  input wire logic open_drain,
  input wire logic pu_req,
  input wire logic pd_req,
  input wire logic analog,
  output logic pad_out,
  output logic pad_oe_n,
  output logic pullup_en,
  output logic pulldown_en,
  output logic analog_en
);
  import iop_pkg::*;

  logic pad_out_ff;
  logic pad_oe_n_ff;
  logic pullup_en_ff;
  logic pulldown_en_ff;
  logic analog_en_ff;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pad_out_ff <= 1'b0;
      pad_oe_n_ff <= 1'b1;
    end
    else
    begin
      // Input releases the pin; analog select does not block the driver
      if (dir_in)
        pad_oe_n_ff <= 1'b1;
      else if (open_drain)
        pad_oe_n_ff <= latch;
      else
        pad_oe_n_ff <= 1'b0;
      pad_out_ff <= latch & ~open_drain;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pullup_en_ff <= 1'b0;
      pulldown_en_ff <= 1'b0;
      analog_en_ff <= 1'b1;
    end
    else
    begin
      pullup_en_ff <= pu_req;
      pulldown_en_ff <= pd_req;
      analog_en_ff <= analog;
    end
  end

  assign pad_out = pad_out_ff;
  assign pad_oe_n = pad_oe_n_ff;
  assign pullup_en = pullup_en_ff;
  assign pulldown_en = pulldown_en_ff;
  assign analog_en = analog_en_ff;
endmodule

//--- iop_pins_model.sv
// Board side of the port pins: drivers, external sources and pulls
`timescale 1ns/1ps
module iop_pins_model #(
  parameter int W = 16
) (
  input wire logic [W-1:0] pad_out,
  input wire logic [W-1:0] pad_oe_n,
  input wire logic [W-1:0] pullup_en,
  input wire logic [W-1:0] pulldown_en,
  input wire logic [W-1:0] ext_en,
  input wire logic [W-1:0] ext_val,
  output logic [W-1:0] pad_in
);
  logic tog = 1'b0;

  // An undriven pin wanders, so a missing input mask cannot pass by luck
  always #3 tog = ~tog;

  always_comb
  begin
    for (int i = 0; i < W; i++)
    begin
      if (!pad_oe_n[i])
        pad_in[i] = pad_out[i];
      else if (ext_en[i])
        pad_in[i] = ext_val[i];
      else if (pullup_en[i] != pulldown_en[i])
        pad_in[i] = pullup_en[i];
      else
        pad_in[i] = tog ^ i[0];
    end
  end
endmodule

//--- iop_pkg.sv
// Types shared by the I/O port modules
package iop_pkg;

  // Base access and its atomic clear, set and invert companions
  typedef enum logic [1:0] {
    IOP_OP_WR,
    IOP_OP_CLR,
    IOP_OP_SET,
    IOP_OP_INV
  } iop_op_t;

endpackage

//--- iop_port.sv
// Digital I/O port with change notification and atomic register access
`timescale 1ns/1ps
`include "iop_map.svh"
// Function
// - Ten registers govern each pin: direction, pins, latch, drain, analog, notify.
// - Direction bit 1 makes the pin an input; 0 drives it.
// - All direction bits come up set after reset.
// - Latch reads return latch contents; latch writes update it.
// - Pin state reads return sampled pins; writes go to the latch.
// - Open-drain bit makes the output drive low only, release for high.
// - Analog select resets to all ones.
// - Output with analog select set still drives the digital level.
// - Pin state reads return zero for analog input pins.
// - Change detection holds the last level while the clock stops, flags a change after restart and requests interrupts.
// - Change enable bit enables the change interrupt for that pin.
// - Change status flags a pin changed since its last pin state read.
// - Pull-up and pull-down enable bits switch on weak pulls.
// - Clear, set, invert writes alter only bits written as one.
// - Companion reads return no meaningful data; read the base register.
module iop_port #(
  parameter int W = 16
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic wr_en,
  input wire logic [`IOP_IDX_W-1:0] wr_sel,
  input wire iop_pkg::iop_op_t wr_op,
  input wire logic [W-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [`IOP_IDX_W-1:0] rd_sel,
  input wire iop_pkg::iop_op_t rd_op,
  output logic [W-1:0] rd_data,
  output logic rd_valid,
  input wire logic [W-1:0] pad_in,
  output logic [W-1:0] pad_out,
  output logic [W-1:0] pad_oe_n,
  output logic [W-1:0] pullup_en,
  output logic [W-1:0] pulldown_en,
  output logic [W-1:0] analog_en,
  output logic change_irq
);
  import iop_pkg::*;

  logic [W-1:0] dir_q;
  logic [W-1:0] lat_q;
  logic [W-1:0] odc_q;
  logic [W-1:0] ansel_q;
  logic [W-1:0] cnen_q;
  logic [W-1:0] cnstat_q;
  logic [W-1:0] cnpu_q;
  logic [W-1:0] cnpd_q;
  logic [W-1:0] cncon_q;

  logic [W-1:0] pin_sample_ff;
  logic [W-1:0] pin_prev_ff;
  logic [W-1:0] rd_data_ff;
  logic [W-1:0] nxt_rd_data;
  logic rd_valid_ff;
  logic change_irq_ff;

  logic [W-1:0] analog_in;
  logic [W-1:0] pin_view;
  logic [W-1:0] change_seen;
  logic [W-1:0] status_clr;
  logic port_base_rd;
  logic cn_on;

  logic wr_dir;
  logic wr_lat;
  logic wr_odc;
  logic wr_ansel;
  logic wr_cnen;
  logic wr_cnstat;
  logic wr_cnpu;
  logic wr_cnpd;
  logic wr_cncon;

  // Write strobes; a pin state write lands in the latch
  assign wr_dir = wr_en && (wr_sel == `IOP_IDX_DIR);
  assign wr_lat = wr_en && ((wr_sel == `IOP_IDX_LAT) ||
                            (wr_sel == `IOP_IDX_PORT));
  assign wr_odc = wr_en && (wr_sel == `IOP_IDX_ODC);
  assign wr_ansel = wr_en && (wr_sel == `IOP_IDX_ANSEL);
  assign wr_cnen = wr_en && (wr_sel == `IOP_IDX_CNEN);
  assign wr_cnstat = wr_en && (wr_sel == `IOP_IDX_CNSTAT);
  assign wr_cnpu = wr_en && (wr_sel == `IOP_IDX_CNPU);
  assign wr_cnpd = wr_en && (wr_sel == `IOP_IDX_CNPD);
  assign wr_cncon = wr_en && (wr_sel == `IOP_IDX_CNCON);

  // Nine stored registers plus the pin view make the ten per port
  iop_reg #(.W(W), .RST_VAL(W'(`IOP_DIR_RST))) u_dir (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .wr_en(wr_dir),
    .wr_op(wr_op),
    .wr_data(wr_data),
    .hw_set('0),
    .hw_clr('0),
    .value(dir_q)
  );

  iop_reg #(.W(W), .RST_VAL(W'(`IOP_ZERO_RST))) u_lat (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .wr_en(wr_lat),
    .wr_op(wr_op),
    .wr_data(wr_data),
    .hw_set('0),
    .hw_clr('0),
    .value(lat_q)
  );

  iop_reg #(.W(W), .RST_VAL(W'(`IOP_ZERO_RST))) u_odc (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .wr_en(wr_odc),
    .wr_op(wr_op),
    .wr_data(wr_data),
    .hw_set('0),
    .hw_clr('0),
    .value(odc_q)
  );

  iop_reg #(.W(W), .RST_VAL(W'(`IOP_ANSEL_RST))) u_ansel (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .wr_en(wr_ansel),
    .wr_op(wr_op),
    .wr_data(wr_data),
    .hw_set('0),
    .hw_clr('0),
    .value(ansel_q)
  );

  iop_reg #(.W(W), .RST_VAL(W'(`IOP_ZERO_RST))) u_cnen (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .wr_en(wr_cnen),
    .wr_op(wr_op),
    .wr_data(wr_data),
    .hw_set('0),
    .hw_clr('0),
    .value(cnen_q)
  );

  iop_reg #(.W(W), .RST_VAL(W'(`IOP_ZERO_RST))) u_cnstat (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .wr_en(wr_cnstat),
    .wr_op(wr_op),
    .wr_data(wr_data),
    .hw_set(change_seen),
    .hw_clr(status_clr),
    .value(cnstat_q)
  );

  iop_reg #(.W(W), .RST_VAL(W'(`IOP_ZERO_RST))) u_cnpu (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .wr_en(wr_cnpu),
    .wr_op(wr_op),
    .wr_data(wr_data),
    .hw_set('0),
    .hw_clr('0),
    .value(cnpu_q)
  );

  iop_reg #(.W(W), .RST_VAL(W'(`IOP_ZERO_RST))) u_cnpd (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .wr_en(wr_cnpd),
    .wr_op(wr_op),
    .wr_data(wr_data),
    .hw_set('0),
    .hw_clr('0),
    .value(cnpd_q)
  );

  iop_reg #(.W(W), .RST_VAL(W'(`IOP_ZERO_RST))) u_cncon (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .wr_en(wr_cncon),
    .wr_op(wr_op),
    .wr_data(wr_data),
    .hw_set('0),
    .hw_clr('0),
    .value(cncon_q)
  );

  // Pin drivers, one per bit
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++)
    begin : g_pad
      iop_pad u_pad (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .dir_in(dir_q[gi]),
        .latch(lat_q[gi]),
        .open_drain(odc_q[gi]),
        .pu_req(cnpu_q[gi]),
        .pd_req(cnpd_q[gi]),
        .analog(ansel_q[gi]),
        .pad_out(pad_out[gi]),
        .pad_oe_n(pad_oe_n[gi]),
        .pullup_en(pullup_en[gi]),
        .pulldown_en(pulldown_en[gi]),
        .analog_en(analog_en[gi])
      );
    end
  endgenerate

  // Pin sampling; one cycle of latency is why software must pause
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      pin_sample_ff <= '0;
    else
      pin_sample_ff <= pad_in;
  end

  // Last seen level is held while the clock stands, so a change made
  // during a clock stop is flagged on the second edge after restart
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      pin_prev_ff <= '0;
    else
      pin_prev_ff <= pin_sample_ff;
  end

  assign cn_on = cncon_q[`IOP_CNCON_ON_BIT];
  assign analog_in = ansel_q & dir_q;
  assign pin_view = pin_sample_ff & ~analog_in;
  assign change_seen = (pin_sample_ff ^ pin_prev_ff) & ~analog_in &
                       {W{cn_on}};
  assign port_base_rd = rd_en && (rd_sel == `IOP_IDX_PORT) &&
                        (rd_op == IOP_OP_WR);
  assign status_clr = {W{port_base_rd}};

  // Read mux; companion reads return zero
  always_comb
  begin
    nxt_rd_data = '0;
    if (rd_op != IOP_OP_WR)
      nxt_rd_data = '0;
    else if (rd_sel == `IOP_IDX_DIR)
      nxt_rd_data = dir_q;
    else if (rd_sel == `IOP_IDX_PORT)
      nxt_rd_data = pin_view;
    else if (rd_sel == `IOP_IDX_LAT)
      nxt_rd_data = lat_q;
    else if (rd_sel == `IOP_IDX_ODC)
      nxt_rd_data = odc_q;
    else if (rd_sel == `IOP_IDX_ANSEL)
      nxt_rd_data = ansel_q;
    else if (rd_sel == `IOP_IDX_CNEN)
      nxt_rd_data = cnen_q;
    else if (rd_sel == `IOP_IDX_CNSTAT)
      nxt_rd_data = cnstat_q;
    else if (rd_sel == `IOP_IDX_CNPU)
      nxt_rd_data = cnpu_q;
    else if (rd_sel == `IOP_IDX_CNPD)
      nxt_rd_data = cnpd_q;
    else if (rd_sel == `IOP_IDX_CNCON)
      nxt_rd_data = cncon_q;
    else
      nxt_rd_data = '0;
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rd_data_ff <= '0;
      rd_valid_ff <= 1'b0;
    end
    else
    begin
      rd_valid_ff <= rd_en;
      if (rd_en)
        rd_data_ff <= nxt_rd_data;
    end
  end

  // Single request for the whole port
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      change_irq_ff <= 1'b0;
    else
      change_irq_ff <= |(cnstat_q & cnen_q);
  end

  assign rd_data = rd_data_ff;
  assign rd_valid = rd_valid_ff;
  assign change_irq = change_irq_ff;
endmodule

//--- iop_port_monitor.sv
// Port-level checker of the I/O port, bound to its top module
`timescale 1ns/1ps
`include "iop_map.svh"
module iop_port_monitor #(
  parameter int W = 16
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic wr_en,
  input wire logic [`IOP_IDX_W-1:0] wr_sel,
  input wire iop_pkg::iop_op_t wr_op,
  input wire logic [W-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [`IOP_IDX_W-1:0] rd_sel,
  input wire iop_pkg::iop_op_t rd_op,
  input wire logic [W-1:0] rd_data,
  input wire logic rd_valid,
  input wire logic [W-1:0] pad_in,
  input wire logic [W-1:0] pad_out,
  input wire logic [W-1:0] pad_oe_n,
  input wire logic [W-1:0] pullup_en,
  input wire logic [W-1:0] pulldown_en,
  input wire logic [W-1:0] analog_en,
  input wire logic change_irq
);
  import iop_pkg::*;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  AST_RD_VALID: assert property (rd_en |=> rd_valid)
    else $error("read answer missing");
  AST_RD_IDLE: assert property (!rd_en |=> !rd_valid)
    else $error("read answer without request");
  AST_COMP_RD_ZERO: assert property (rd_en && rd_op != IOP_OP_WR |=>
    rd_data == '0) else $error("companion read not zero");
  AST_DIR_SET_IN: assert property (wr_en && wr_sel == `IOP_IDX_DIR &&
    wr_op == IOP_OP_SET |=> ##1
    (pad_oe_n & $past(wr_data, 2)) == $past(wr_data, 2))
    else $error("pin still driven after direction set");
  AST_RST_INPUTS: assert property ($rose(arst_n) |-> pad_oe_n == '1)
    else $error("pins driven after reset");
  AST_RST_ANALOG: assert property ($rose(arst_n) |-> analog_en == '1)
    else $error("analog select not all ones after reset");
  AST_PU_WRITE: assert property (wr_en && wr_sel == `IOP_IDX_CNPU &&
    wr_op == IOP_OP_WR |=> ##1 pullup_en == $past(wr_data, 2))
    else $error("pull-up enables do not follow write");
  AST_PD_CLR: assert property (wr_en && !$past(wr_en) &&
    wr_sel == `IOP_IDX_CNPD && wr_op == IOP_OP_CLR |=> ##1
    pulldown_en == ($past(pulldown_en, 2) & ~$past(wr_data, 2)))
    else $error("clear companion touched other bits");
  AST_IRQ_RISE: assert property ($rose(change_irq) |->
    $past(wr_en, 2) || $past(pad_in, 3) != $past(pad_in, 4))
    else $error("change request without cause");
  AST_IRQ_FALL: assert property ($fell(change_irq) |->
    $past(wr_en, 2) || $past(rd_en, 2))
    else $error("change request dropped without access");
endmodule

bind iop_port iop_port_monitor #(.W(W)) mon_u (.core_clk, .arst_n, .wr_en,
  .wr_sel, .wr_op, .wr_data, .rd_en, .rd_sel, .rd_op, .rd_data, .rd_valid,
  .pad_in, .pad_out, .pad_oe_n, .pullup_en, .pulldown_en, .analog_en,
  .change_irq);

//--- iop_port_tb.sv
// Self-checking testbench of the I/O port
`timescale 1ns/1ps
`include "iop_map.svh"
module iop_port_tb;
  import iop_pkg::*;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [3:0] wr_sel = 4'h0;
  logic [3:0] rd_sel = 4'h0;
  iop_op_t wr_op = IOP_OP_WR;
  iop_op_t rd_op = IOP_OP_WR;
  logic [15:0] wr_data = 16'h0000;
  logic [15:0] ext_en = 16'h0000;
  logic [15:0] ext_val = 16'h0000;
  logic [15:0] rd_data, pad_in, pad_out, pad_oe_n;
  logic [15:0] pullup_en, pulldown_en, analog_en;
  logic rd_valid, change_irq;
  int mismatches = 0;
  int checks = 0;

  always #4 core_clk = ~core_clk;

  iop_port #(.W(16)) dut_u (.core_clk, .arst_n, .wr_en, .wr_sel, .wr_op,
    .wr_data, .rd_en, .rd_sel, .rd_op, .rd_data, .rd_valid, .pad_in,
    .pad_out, .pad_oe_n, .pullup_en, .pulldown_en, .analog_en, .change_irq);
  iop_pins_model #(.W(16)) pins_u (.pad_out, .pad_oe_n, .pullup_en,
    .pulldown_en, .ext_en, .ext_val, .pad_in);

  task automatic chk(input string nm, input logic [15:0] seen, exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] s, input iop_op_t op, logic [15:0] d);
    @(negedge core_clk);
    wr_en = 1'b1;
    wr_sel = s;
    wr_op = op;
    wr_data = d;
    @(negedge core_clk);
    wr_en = 1'b0;
  endtask

  task automatic rd(input logic [3:0] s, input iop_op_t op, logic [15:0] e);
    // Leaves an idle cycle after any write
    @(negedge core_clk);
    rd_en = 1'b1;
    rd_sel = s;
    rd_op = op;
    @(negedge core_clk);
    rd_en = 1'b0;
    chk("rd_valid", {15'h0000, rd_valid}, 16'h0001);
    chk("rd_data", rd_data, e);
  endtask

  task automatic t_reset();
    logic [15:0] e [10] = '{16'hffff, 16'h0000, 16'h0000, 16'h0000,
      16'hffff, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    for (int i = 0; i < 10; i++)
      rd(4'(i), IOP_OP_WR, e[i]);
    chk("analog_en", analog_en, 16'hffff);
    chk("pad_oe_n", pad_oe_n, 16'hffff);
    rd(`IOP_IDX_PORT, IOP_OP_WR, 16'h0000);
    rd(4'hc, IOP_OP_WR, 16'h0000);
    rd(`IOP_IDX_DIR, IOP_OP_SET, 16'h0000);
    wr(`IOP_IDX_DIR, IOP_OP_SET, 16'h0001);
  endtask

  task automatic t_output();
    wr(`IOP_IDX_ANSEL, IOP_OP_CLR, 16'hffff);
    wr(`IOP_IDX_DIR, IOP_OP_CLR, 16'h00ff);
    wr(`IOP_IDX_LAT, IOP_OP_WR, 16'ha5c3);
    ext_en = 16'hff00;
    ext_val = 16'h1200;
    @(negedge core_clk);
    chk("pad_oe_n", pad_oe_n, 16'hff00);
    chk("pad_out", pad_out & 16'h00ff, 16'h00c3);
    rd(`IOP_IDX_LAT, IOP_OP_WR, 16'ha5c3);
    rd(`IOP_IDX_PORT, IOP_OP_WR, 16'h12c3);
    wr(`IOP_IDX_PORT, IOP_OP_WR, 16'h0f0f);
    rd(`IOP_IDX_LAT, IOP_OP_WR, 16'h0f0f);
    wr(`IOP_IDX_ANSEL, IOP_OP_SET, 16'h0001);
    @(negedge core_clk);
    chk("pad_out", pad_out & 16'h00ff, 16'h000f);
    chk("analog_en", analog_en, 16'h0001);
    chk("pad_oe_n", pad_oe_n & 16'h0001, 16'h0000);
    // Pin 0 held high from outside, so only the analog mask reads it low
    ext_en = 16'hff01;
    ext_val = 16'h1201;
    wr(`IOP_IDX_DIR, IOP_OP_SET, 16'h0001);
    rd(`IOP_IDX_PORT, IOP_OP_WR, 16'h120e);
    ext_en = 16'hff00;
    ext_val = 16'h1200;
    wr(`IOP_IDX_DIR, IOP_OP_CLR, 16'h0001);
    wr(`IOP_IDX_ANSEL, IOP_OP_CLR, 16'h0001);
  endtask

  task automatic t_atomic();
    wr(`IOP_IDX_LAT, IOP_OP_SET, 16'h00f0);
    wr(`IOP_IDX_LAT, IOP_OP_CLR, 16'h000f);
    wr(`IOP_IDX_LAT, IOP_OP_INV, 16'hff00);
    rd(`IOP_IDX_LAT, IOP_OP_WR, 16'hf0f0);
    rd(`IOP_IDX_LAT, IOP_OP_INV, 16'h0000);
  endtask

  task automatic t_odrain();
    wr(`IOP_IDX_ODC, IOP_OP_SET, 16'h0003);
    wr(`IOP_IDX_LAT, IOP_OP_SET, 16'h0001);
    @(negedge core_clk);
    chk("pad_oe_n", pad_oe_n & 16'h0003, 16'h0001);
    chk("pad_out", pad_out & 16'h0003, 16'h0000);
    wr(`IOP_IDX_ODC, IOP_OP_CLR, 16'h0003);
  endtask

  task automatic t_pulls();
    wr(`IOP_IDX_CNPU, IOP_OP_WR, 16'h00aa);
    wr(`IOP_IDX_CNPD, IOP_OP_WR, 16'h5500);
    wr(`IOP_IDX_CNPD, IOP_OP_CLR, 16'h0500);
    @(negedge core_clk);
    chk("pullup_en", pullup_en, 16'h00aa);
    chk("pulldown_en", pulldown_en, 16'h5000);
    rd(`IOP_IDX_CNPD, IOP_OP_WR, 16'h5000);
    wr(`IOP_IDX_CNPU, IOP_OP_CLR, 16'hffff);
    wr(`IOP_IDX_CNPD, IOP_OP_CLR, 16'hffff);
  endtask

  task automatic t_change();
    int n;
    wr(`IOP_IDX_CNCON, IOP_OP_WR, 16'h8000);
    wr(`IOP_IDX_CNEN, IOP_OP_WR, 16'h0100);
    rd(`IOP_IDX_PORT, IOP_OP_WR, 16'h12f1);
    ext_val = 16'h1300;
    n = 0;
    while (change_irq !== 1'b1 && n < 8)
    begin
      @(negedge core_clk);
      n++;
    end
    chk("change_irq", {15'h0000, change_irq}, 16'h0001);
    rd(`IOP_IDX_CNSTAT, IOP_OP_WR, 16'h0100);
    rd(`IOP_IDX_PORT, IOP_OP_WR, 16'h13f1);
    repeat (2) @(negedge core_clk);
    chk("change_irq", {15'h0000, change_irq}, 16'h0000);
    rd(`IOP_IDX_CNSTAT, IOP_OP_WR, 16'h0000);
    ext_val = 16'h1100;
    repeat (4) @(negedge core_clk);
    chk("change_irq", {15'h0000, change_irq}, 16'h0000);
    rd(`IOP_IDX_CNSTAT, IOP_OP_WR, 16'h0200);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (3) @(negedge core_clk);
    arst_n = 1'b1;
    t_reset();
    t_output();
    t_atomic();
    t_odrain();
    t_pulls();
    t_change();
    wrap_up();
  end

  // Whole sequence needs well under 300 cycles
  initial
  begin
    #20000;
    mismatches++;
    wrap_up();
  end
endmodule

//--- iop_reg.sv
// One port register with atomic clear, set and invert write forms
`timescale 1ns/1ps
module iop_reg #(
  parameter int W = 16,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic wr_en,
  input wire iop_pkg::iop_op_t wr_op,
  input wire logic [W-1:0] wr_data,
  input wire logic [W-1:0] hw_set,
  input wire logic [W-1:0] hw_clr,
  output logic [W-1:0] value
);
  import iop_pkg::*;

  logic [W-1:0] value_ff;
  logic [W-1:0] nxt_value;
  logic [W-1:0] sw_value;

  always_comb
  begin
    sw_value = value_ff;
    if (wr_en)
    begin
      case (wr_op)
        IOP_OP_WR: sw_value = wr_data;
        IOP_OP_CLR: sw_value = value_ff & ~wr_data;
        IOP_OP_SET: sw_value = value_ff | wr_data;
        default: sw_value = value_ff ^ wr_data;
      endcase
    end
    // Hardware set wins so an event in the clearing cycle is kept
    nxt_value = (sw_value & ~hw_clr) | hw_set;
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      value_ff <= RST_VAL;
    else
      value_ff <= nxt_value;
  end

  assign value = value_ff;
endmodule
